// *** pkg/rocof_defines.svh ***
// constants of the frequency rate-of-change protection stage
`ifndef ROCOF_DEFINES_SVH
`define ROCOF_DEFINES_SVH

`define CLK_PERIOD_NS   100
`define TICK_PERIOD_NS  1000000
`define TICK_CYCLES_DFLT (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`define PICKUP_MS       16'h0050
`define START_MS        16'h003c
`define RELEASE_MS      16'h0050
`define TIME_UNIT_MS    16'h000a
`define PCT_FULL        16'h0064

`define SLOPE_MIN       16'h0002
`define SLOPE_MAX       16'h0064
`define SLOPE_DFLT      16'h0032
`define DLY_MIN         16'h000e
`define DLY_MAX         16'h03e8
`define DLY_DFLT        16'h0032

`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_START_COUNT 8'h08
`define OFS_TRIP_COUNT  8'h0c
`define OFS_FLT_MAX     8'h10
`define OFS_FLT_ELAPSED_DELAY_PCT    8'h14
`define OFS_MEAS_SLOPE  8'h18
`define GRP_REGION      2'b01
`define FLD_SLOPE       2'h0
`define FLD_OPDLY       2'h1
`define FLD_MINDLY      2'h2

`define CTRL_RESET      32'h00000f00
`define CTRL_MAN_LSB    0
`define CTRL_SRC_LSB    2
`define CTRL_VIRT_LSB   4
`define CTRL_EN_LSB     8
`define EN_START_ON     0
`define EN_START_OFF    1
`define EN_TRIP_ON      2
`define EN_TRIP_OFF     3

`endif

// *** pkg/rocof_pkg.sv ***
// types shared by the rate-of-change protection stage
package rocof_pkg;
  typedef enum {ST_IDLE, ST_PICKED} stage_state_t;
  typedef enum logic [1:0] {SRC_MANUAL, SRC_DIGITAL, SRC_VIRTUAL} grp_src_t;
endpackage

// *** hw/rocof_stage.sv ***
// frequency rate-of-change protection stage with ahb-lite registers
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rocof_defines.svh"
// Summary of operation
// R1 - pick up after the absolute slope stays above the setting for 80 ms.
// R2 - assert start 60 ms after the pick-up instant.
// R3 - trip when the average slope since pick-up is above the setting.
// R4 - software sets minimum delay equal to operate delay for definite time.
// R5 - release after about 80 ms of stable frequency once t passed untripped.
// R6 - slope fluctuations while picked up do not release; averaging goes on.
// R7 - with a shorter minimum delay trip time is setting times t over slope.
// R8 - trip time is never shorter than the minimum delay setting.
// R9 - slope setting spans 0.2 to 10.0 Hz/s, default 5.0 Hz/s.
// R10 - operate delay spans 0.14 to 10.0 s, default 0.50 s.
// R11 - minimum delay spans 0.14 to 10.0 s, default 0.50 s.
// R12 - four enables, default on, gate start and trip on and off events.
// R13 - cumulative start and trip counters are readable by software.
// R14 - each fault records its peak slope as a percentage of the setting.
// R15 - each fault records elapsed time as percent of t, 100 meaning trip.
// R16 - four setting groups chosen by digital, virtual or manual selection.
// R17 - release clears start and trip; counters count rising edges only.
module rocof_stage
  import rocof_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES_DFLT
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:0] freq_slope,
  input  wire logic [1:0]  grp_pins,
  output logic             start,
  output logic             trip,
  output logic             evt_start_on,
  output logic             evt_start_off,
  output logic             evt_trip_on,
  output logic             evt_trip_off
);

  function automatic logic [15:0] clamp(input logic [31:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    return (v < {16'h0000, lo}) ? lo :
           (v > {16'h0000, hi}) ? hi : v[15:0];
  endfunction

  function automatic logic [15:0] pct(input logic [15:0] num,
                                      input logic [15:0] den);
    logic [31:0] q;
    q = ({16'h0000, num} * {16'h0000, `PCT_FULL}) / {16'h0000, den};
    return q[15:0];
  endfunction

  // bus slave, zero wait states
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rdata_reg;
  logic        hreadyout_reg;
  logic        hresp_reg;
  wire         addr_phase = hsel && hready && htrans[1];
  logic [31:0] read_mux;

  // settings and control
  logic [15:0] slope_set_reg [4];
  logic [15:0] opdly_reg     [4];
  logic [15:0] mindly_reg    [4];
  logic [31:0] ctrl_reg;
  logic [1:0]  grp_meta_reg;
  logic [1:0]  grp_sync_reg;

  wire [1:0] grp_src  = ctrl_reg[`CTRL_SRC_LSB +: 2];
  wire [1:0] grp_man  = ctrl_reg[`CTRL_MAN_LSB +: 2];
  wire [1:0] grp_virt = ctrl_reg[`CTRL_VIRT_LSB +: 2];
  wire [3:0] evt_en   = ctrl_reg[`CTRL_EN_LSB +: 4];
  wire [1:0] act_grp  = (grp_src == SRC_DIGITAL) ? grp_sync_reg :    // R16
                        (grp_src == SRC_VIRTUAL) ? grp_virt : grp_man;

  wire        wr_grp   = wr_pend_reg && wr_addr_reg[7:6] == `GRP_REGION;
  wire [1:0]  wr_g     = wr_addr_reg[5:4];
  wire [1:0]  wr_fld   = wr_addr_reg[3:2];
  wire        wr_ctrl  = wr_pend_reg && wr_addr_reg == `OFS_CTRL;
  wire        clr_scnt = wr_pend_reg && wr_addr_reg == `OFS_START_COUNT;
  wire        clr_tcnt = wr_pend_reg && wr_addr_reg == `OFS_TRIP_COUNT;

  wire [15:0] set_slope = slope_set_reg[act_grp];
  wire [15:0] t_ms      = 16'(opdly_reg[act_grp] * `TIME_UNIT_MS);
  wire [15:0] minimum_delay_setting_ms   = 16'(mindly_reg[act_grp] * `TIME_UNIT_MS);
  // stage state
  logic        tick_reg;
  logic [15:0] tick_cnt_reg;
  stage_state_t state_reg;
  logic [15:0] over_cnt_reg;
  logic [15:0] stable_cnt_reg;
  logic [15:0] elapsed_reg;
  logic [31:0] sum_reg;
  logic [15:0] max_reg;
  logic        start_reg;
  logic        trip_reg;
  logic [31:0] start_count_reg;
  logic [31:0] trip_count_reg;
  logic [15:0] flt_max_reg;
  logic [15:0] flt_elapsed_delay_pct_reg;
  logic [3:0]  evt_reg;

  wire        picked    = state_reg == ST_PICKED;
  wire        tick_wrap = tick_cnt_reg == 16'(TICK_CYCLES - 1);
  wire [15:0] abs_slope = freq_slope[15] ? 16'(-freq_slope) : freq_slope;
  wire        above     = abs_slope > set_slope;
  wire [31:0] set_t     = {16'h0000, set_slope} * {16'h0000, t_ms};
  wire [31:0] set_el    = {16'h0000, set_slope} * {16'h0000, elapsed_reg};

  // average above setting without a divider: sum > setting * elapsed
  wire avg_above = sum_reg > set_el;                                 // R3
  // elapsed >= setting*t/avg rearranged to sum >= setting*t
  wire inv_due   = sum_reg >= set_t;                                 // R7
  wire trip_cond = picked && elapsed_reg != 16'h0000 && avg_above &&
                   inv_due && elapsed_reg >= minimum_delay_setting_ms;                // R8
  wire pickup    = tick_reg && !picked && above &&
                   over_cnt_reg == `PICKUP_MS - 16'h0001;            // R1
  wire release_now = tick_reg && picked && !above &&
                     stable_cnt_reg == `RELEASE_MS - 16'h0001 &&
                     (trip_reg || elapsed_reg >= t_ms);              // R5
  wire start_next = !release_now && picked &&
                    elapsed_reg >= `START_MS;                        // R2
  wire trip_next  = !release_now && (trip_reg || trip_cond);         // R17
  wire start_rise = start_next && !start_reg;
  wire start_fall = !start_next && start_reg;
  wire trip_rise  = trip_next && !trip_reg;
  wire trip_fall  = !trip_next && trip_reg;

  always_comb begin
    read_mux = 32'h00000000;
    if (haddr[7:6] == `GRP_REGION) begin
      case (haddr[3:2])
        `FLD_SLOPE:  read_mux = {16'h0000, slope_set_reg[haddr[5:4]]};
        `FLD_OPDLY:  read_mux = {16'h0000, opdly_reg[haddr[5:4]]};
        `FLD_MINDLY: read_mux = {16'h0000, mindly_reg[haddr[5:4]]};
        default:     read_mux = 32'h00000000;
      endcase
    end else begin
      case (haddr)
        `OFS_CTRL:        read_mux = ctrl_reg;
        `OFS_STATUS:      read_mux = {26'h0, act_grp, 1'b0, picked,
                                      trip_reg, start_reg};
        `OFS_START_COUNT: read_mux = start_count_reg;                // R13
        `OFS_TRIP_COUNT:  read_mux = trip_count_reg;                 // R13
        `OFS_FLT_MAX:     read_mux = {16'h0000, flt_max_reg};
        `OFS_FLT_ELAPSED_DELAY_PCT:    read_mux = {16'h0000, flt_elapsed_delay_pct_reg};
        `OFS_MEAS_SLOPE:  read_mux = {16'h0000, abs_slope};
        default:          read_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
      rdata_reg     <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr;
      if (addr_phase && !hwrite) begin
        rdata_reg <= read_mux;
      end
    end
  end

  // writes out of range are clamped, so settings never leave their span
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `CTRL_RESET;                                       // R12
      for (int g = 0; g < 4; g++) begin
        slope_set_reg[g] <= `SLOPE_DFLT;                             // R9
        opdly_reg[g]     <= `DLY_DFLT;                               // R10
        mindly_reg[g]    <= `DLY_DFLT;                               // R11
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {20'h00000, hwdata[11:8], 2'b00, hwdata[5:0]};
      end
      if (wr_grp && wr_fld == `FLD_SLOPE) begin
        slope_set_reg[wr_g] <= clamp(hwdata, `SLOPE_MIN, `SLOPE_MAX); // R9
      end
      if (wr_grp && wr_fld == `FLD_OPDLY) begin
        opdly_reg[wr_g] <= clamp(hwdata, `DLY_MIN, `DLY_MAX);        // R10
      end
      if (wr_grp && wr_fld == `FLD_MINDLY) begin
        mindly_reg[wr_g] <= clamp(hwdata, `DLY_MIN, `DLY_MAX);       // R11
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grp_meta_reg <= 2'b00;
      grp_sync_reg <= 2'b00;
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else begin
      grp_meta_reg <= grp_pins;
      grp_sync_reg <= grp_meta_reg;
      tick_reg     <= tick_wrap;
      tick_cnt_reg <= tick_wrap ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // 1 ms timebase for pick-up, stability and elapsed time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg      <= ST_IDLE;
      over_cnt_reg   <= 16'h0000;
      stable_cnt_reg <= 16'h0000;
      elapsed_reg    <= 16'h0000;
      sum_reg        <= 32'h00000000;
      max_reg        <= 16'h0000;
    end else if (tick_reg) begin
      case (state_reg)
        ST_IDLE: begin
          over_cnt_reg <= above ? over_cnt_reg + 16'h0001 : 16'h0000;
          if (pickup) begin
            state_reg      <= ST_PICKED;
            elapsed_reg    <= 16'h0000;
            sum_reg        <= 32'h00000000;
            max_reg        <= abs_slope;
            stable_cnt_reg <= 16'h0000;
            over_cnt_reg   <= 16'h0000;
          end
        end
        ST_PICKED: begin
          // dips of the slope only count toward release, never reset sums
          if (above) begin
            stable_cnt_reg <= 16'h0000;                              // R6
          end else if (stable_cnt_reg != `RELEASE_MS - 16'h0001) begin
            stable_cnt_reg <= stable_cnt_reg + 16'h0001;
          end
          elapsed_reg <= elapsed_reg + {15'h0000, elapsed_reg != 16'hffff};
          sum_reg <= sum_reg + {16'h0000, abs_slope};                // R6
          max_reg <= (abs_slope > max_reg) ? abs_slope : max_reg;
          if (release_now) begin
            state_reg <= ST_IDLE;                                    // R5
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_reg       <= 1'b0;
      trip_reg        <= 1'b0;
      start_count_reg <= 32'h00000000;
      trip_count_reg  <= 32'h00000000;
      flt_max_reg     <= 16'h0000;
      flt_elapsed_delay_pct_reg    <= 16'h0000;
      evt_reg         <= 4'h0;
    end else begin
      start_reg <= start_next;                                       // R17
      trip_reg  <= trip_next;                                        // R17
      // a count edge in the clearing cycle is kept
      start_count_reg <= (clr_scnt ? 32'h00000000 : start_count_reg) +
                         {31'h0, start_rise};                        // R13 R17
      trip_count_reg  <= (clr_tcnt ? 32'h00000000 : trip_count_reg) +
                         {31'h0, trip_rise};                         // R13 R17
      if (release_now) begin
        flt_max_reg  <= pct(max_reg, set_slope);                     // R14
        flt_elapsed_delay_pct_reg <= trip_reg ? `PCT_FULL : pct(elapsed_reg, t_ms); // R15
      end
      evt_reg <= {trip_fall  && evt_en[`EN_TRIP_OFF],
                  trip_rise  && evt_en[`EN_TRIP_ON],
                  start_fall && evt_en[`EN_START_OFF],
                  start_rise && evt_en[`EN_START_ON]};               // R12
    end
  end

  assign hreadyout     = hreadyout_reg;
  assign hresp         = hresp_reg;
  assign hrdata        = rdata_reg;
  assign start         = start_reg;
  assign trip          = trip_reg;
  assign evt_start_on  = evt_reg[`EN_START_ON];
  assign evt_start_off = evt_reg[`EN_START_OFF];
  assign evt_trip_on   = evt_reg[`EN_TRIP_ON];
  assign evt_trip_off  = evt_reg[`EN_TRIP_OFF];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_PICKUP_COUNT: assert property ( // R1
    $rose(picked) |-> $past(over_cnt_reg) == `PICKUP_MS - 16'h0001
  ) else $error("pick-up without full run of slope above setting");
  AST_START_DELAY: assert property ( // R2
    $rose(start_reg) |-> $past(picked) && $past(elapsed_reg) == `START_MS
  ) else $error("start not at the set delay after pick-up");
  AST_TRIP_AVERAGE: assert property ( // R3
    $rose(trip_reg) |-> $past(sum_reg) > $past(set_el)
  ) else $error("trip with average slope not above setting");
  AST_RELEASE_STABLE: assert property ( // R5
    $fell(picked) |-> $past(stable_cnt_reg) == `RELEASE_MS - 16'h0001
  ) else $error("release before the stable period");
  AST_SUM_KEPT: assert property ( // R6
    picked && $past(picked) |-> sum_reg >= $past(sum_reg)
  ) else $error("slope sum lost while picked up");
  AST_INVERSE_TIME: assert property ( // R7
    $rose(trip_reg) |-> $past(sum_reg) >= $past(set_t)
  ) else $error("trip before inverse time reached");
  AST_MIN_DELAY: assert property ( // R8
    $rose(trip_reg) |-> $past(elapsed_reg) >= $past(minimum_delay_setting_ms)
  ) else $error("trip before minimum delay");
  AST_SLOPE_RANGE: assert property ( // R9
    set_slope >= `SLOPE_MIN && set_slope <= `SLOPE_MAX
  ) else $error("slope setting out of range");
  AST_START_EVENT: assert property ( // R12
    $rose(start_reg) && $past(evt_en[`EN_START_ON]) |-> evt_start_on
  ) else $error("start event missing");
  AST_START_COUNT: assert property ( // R13
    $rose(start_reg) && !$past(clr_scnt) |->
      start_count_reg == $past(start_count_reg) + 32'h00000001
  ) else $error("start counter not stepped");
  AST_ELAPSED_DELAY_PCT_TRIP: assert property ( // R15
    $fell(picked) && $past(trip_reg) |-> flt_elapsed_delay_pct_reg == `PCT_FULL
  ) else $error("tripped fault not recorded as full time");
  AST_RELEASE_CLEARS: assert property ( // R17
    $fell(picked) |-> !start_reg && !trip_reg
  ) else $error("start or trip left after release");

endmodule

// *** verif/freq_front_end.sv ***
// model of the frequency front end feeding the slope input
`timescale 1ns/1ps
module freq_front_end #(
  parameter int MS_CYCLES = 10
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] level,
  input  wire logic [15:0] wobble,
  output logic      [15:0] freq_slope
);
  int   ms_cnt;
  logic phase;
  // wobble flips each ms so the long-run average stays on level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt     <= 0;
      phase      <= 1'b0;
      freq_slope <= 16'h0000;
    end else begin
      ms_cnt     <= (ms_cnt == MS_CYCLES - 1) ? 0 : ms_cnt + 1;
      phase      <= (ms_cnt == MS_CYCLES - 1) ? ~phase : phase;
      freq_slope <= phase ? level - wobble : level + wobble;
    end
  end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench of the rate-of-change protection stage
`timescale 1ns/1ps
`include "rocof_defines.svh"
module tb_top
  import rocof_pkg::*;
;
  localparam int TICK  = 10;
  localparam int LIMIT = 60000;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00, grp_pins = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [15:0] level = 16'h0, wobble = 16'h0, freq_slope;
  logic        hreadyout, hresp, start, trip, st_q = 1'b0, tr_q = 1'b0;
  logic        e_son, e_soff, e_ton, e_toff;
  wire         hready = hreadyout;
  int          err_count = 0, comparisons = 0, cyc = 0;
  int          t_srise, t_sfall, t_trise;
  int          n_ev[4] = '{0, 0, 0, 0};

  always #50 hclk = ~hclk;

  rocof_stage #(.TICK_CYCLES(TICK)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .freq_slope(freq_slope), .grp_pins(grp_pins),
    .start(start), .trip(trip), .evt_start_on(e_son),
    .evt_start_off(e_soff), .evt_trip_on(e_ton), .evt_trip_off(e_toff)
  );

  freq_front_end #(.MS_CYCLES(TICK)) fe (
    .hclk(hclk), .hresetn(hresetn), .level(level), .wobble(wobble),
    .freq_slope(freq_slope)
  );

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc     <= cyc + 1;
    st_q    <= start;
    tr_q    <= trip;
    n_ev[0] <= n_ev[0] + int'(e_son === 1'b1);
    n_ev[1] <= n_ev[1] + int'(e_soff === 1'b1);
    n_ev[2] <= n_ev[2] + int'(e_ton === 1'b1);
    n_ev[3] <= n_ev[3] + int'(e_toff === 1'b1);
    if (start === 1'b1 && st_q === 1'b0) t_srise <= cyc;
    if (start === 1'b0 && st_q === 1'b1) t_sfall <= cyc;
    if (trip === 1'b1 && tr_q === 1'b0) t_trise <= cyc;
    if (cyc == LIMIT) begin
      err_count = err_count + 1;
      $display("MISMATCH %0t run too long", $time);
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic near(input int d, input int e);
    return (d >= e - 25) && (d <= e + 25);
  endfunction

  function automatic logic [7:0] ga(input int g, input int f);
    return 8'(8'h40 + g * 16 + f * 4);
  endfunction

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
    r = hrdata;
    check(hresp, 1'b0);
    check(hreadyout, 1'b1);
    // a read straight after a write would already see the written value
    if (w) @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, e);
  endtask

  // one fault: onset, start, optional trip, drop and release
  task automatic fault(input logic [15:0] lv, input logic [15:0] wb,
                       input int trip_ms, input logic [15:0] low,
                       input logic [3:0] ev_exp);
    int t0;
    int ev0[4];
    logic [31:0] r;
    ev0 = n_ev;
    t0 = cyc;
    level <= lv;
    repeat (3000) if (start !== 1'b1) @(posedge hclk);
    @(posedge hclk);
    check(near(t_srise - t0, 140 * TICK), 1'b1);
    if (trip_ms > 0) begin
      wobble <= wb;
      repeat (20000) if (trip !== 1'b1) @(posedge hclk);
      @(posedge hclk);
      check(near(t_trise - t0, (80 + trip_ms) * TICK), 1'b1);
      bus(1'b0, `OFS_STATUS, 32'h0, r);
      check(r[2:0], 3'b111);
    end
    t0 = cyc;
    level  <= low;
    wobble <= 16'h0;
    repeat (20000) if (start !== 1'b0) @(posedge hclk);
    check(trip, 1'b0);
    repeat (3) @(posedge hclk);
    if (trip_ms > 0) check(near(t_sfall - t0, 80 * TICK), 1'b1);
    for (int i = 0; i < 4; i++) check(n_ev[i] - ev0[i], ev_exp[i]);
  endtask

  initial begin
    int v, f, w;
    int cv[4] = '{1, 200, 5, 2000};
    int cf[4] = '{0, 0, 1, 2};
    int ce[4] = '{`SLOPE_MIN, `SLOPE_MAX, `DLY_MIN, `DLY_MAX};
    void'($urandom(66));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int g = 0; g < 16; g++)
      rc(ga(g / 4, g % 4 % 3), g % 4 % 3 ? `DLY_DFLT : `SLOPE_DFLT);
    rc(`OFS_CTRL, `CTRL_RESET);
    rc(`OFS_START_COUNT, 32'h0);
    wr(8'h30, 32'h1234);
    rc(8'h30, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ga(3, cf[i]), cv[i]);
      rc(ga(3, cf[i]), ce[i]);
    end
    for (int i = 0; i < 6; i++) begin
      f = $urandom_range(2, 0);
      v = f ? $urandom_range(1000, 14) : $urandom_range(100, 2);
      wr(ga(2, f), v);
      rc(ga(2, f), v);
    end
    $display("test registers done");
    for (int g = 0; g < 4; g++) begin
      wr(`OFS_CTRL, 32'hf00 | g);
      rc(`OFS_STATUS, g << 4);
      grp_pins <= 2'(g);
      wr(`OFS_CTRL, 32'hf04);
      repeat (4) @(posedge hclk);
      rc(`OFS_STATUS, g << 4);
      wr(`OFS_CTRL, 32'hf08 | (g << 4));
      rc(`OFS_STATUS, g << 4);
    end
    $display("test groups done");
    wr(`OFS_CTRL, 32'hf00);
    wr(ga(0, 1), 20);
    wr(ga(0, 2), 20);
    w = $urandom_range(45, 31);
    fault(16'd80, 16'(w), 200, 16'h0, 4'hf);
    rc(`OFS_START_COUNT, 1);
    rc(`OFS_TRIP_COUNT, 1);
    rc(`OFS_FLT_MAX, (80 + w) * 100 / 50);
    rc(`OFS_FLT_ELAPSED_DELAY_PCT, `PCT_FULL);
    $display("test definite done");
    wr(ga(1, 1), 40);
    wr(ga(1, 2), 14);
    wr(`OFS_CTRL, 32'hf01);
    fault(16'd100, 16'h0, 200, 16'h0, 4'hf);
    rc(`OFS_FLT_MAX, 200);
    rc(`OFS_FLT_ELAPSED_DELAY_PCT, `PCT_FULL);
    $display("test inverse done");
    fault(16'hff06, 16'h0, 140, 16'h0, 4'hf);
    rc(`OFS_FLT_MAX, 500);
    rc(`OFS_TRIP_COUNT, 3);
    $display("test minimum done");
    wr(`OFS_CTRL, 32'he00);
    fault(16'd60, 16'h0, 0, 16'd20, 4'b0010);
    rc(`OFS_FLT_MAX, 120);
    rc(`OFS_MEAS_SLOPE, 20);
    rc(`OFS_START_COUNT, 4);
    rc(`OFS_TRIP_COUNT, 3);
    wr(`OFS_START_COUNT, 0);
    rc(`OFS_START_COUNT, 0);
    wr(`OFS_TRIP_COUNT, 0);
    rc(`OFS_TRIP_COUNT, 0);
    $display("test no trip done");
    wrap_up();
  end
endmodule
